// ### rtl/udg_pkg.sv
`default_nettype none
package udg_pkg;

    // bit-rate divider width and the plain default reload
    localparam int          BRG_W         = 16;
    localparam logic [15:0] BRG_RESET     = 16'h001B;
    localparam int          DATA_W        = 8;
    // one start, eight data, one parity, one stop
    localparam logic [3:0]  FRAME_BITS    = 4'hB;
    localparam logic [3:0]  LEAD_BITS     = 4'h1;
    localparam logic [3:0]  BIT_ZERO      = 4'h0;
    localparam logic [15:0] CNT_ONE       = 16'h0001;
    localparam logic [15:0] CNT_ZERO      = 16'h0000;

    typedef enum logic [3:0] {
        UDG_IDLE  = 4'b0001,
        UDG_LEAD  = 4'b0010,
        UDG_SEND  = 4'b0100,
        UDG_TAIL  = 4'b1000
    } udg_state_t;

    // serial control bits, first control register image
    typedef struct packed {
        logic serial_enable;
        logic parity_enable;
        logic parity_odd;
        logic drive_gate_polarity;
    } udg_ctrl_t;

endpackage
`default_nettype wire

// ### rtl/udg_hold.sv
`timescale 1ns/100ps
`default_nettype none
// transmit holding register with a valid flag
module udg_hold
    import udg_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              reset_i,
    // write side
    input  wire logic              wr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    // take side
    input  wire logic              take_i,
    output logic                   valid_o,
    output logic [DATA_W-1:0]      rdata_o
);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= '0;
        end else if (wr_i) begin
            rdata_o <= wdata_i;
        end
    end

    // a write in the take cycle keeps the flag set
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            valid_o <= 1'b0;
        end else if (wr_i) begin
            valid_o <= 1'b1;
        end else if (take_i) begin
            valid_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### rtl/udg_tx.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - with default polarity the drive gate is high over start, data, parity and stop bits.
// - a write to the transmit data register starts activation of the drive gate.
// - the gate turns on two bit periods before the start bit.
// - the gate turns off one clock after the last stop bit when nothing is pending.
// - a byte written before the current frame ends keeps the gate on between frames.
// - the active level of the gate follows the polarity bit of control register one.
// - transmit and receive paths each have their own interrupt request.
// - with the serial function off the bit-rate generator acts as a timer with interrupt.
module udg_tx
    import udg_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              reset_i,
    // control
    input  wire udg_ctrl_t         ctrl_i,
    input  wire logic [BRG_W-1:0]  brg_reload_i,
    // transmit data register write
    input  wire logic              tx_wr_i,
    input  wire logic [DATA_W-1:0] tx_data_i,
    // receive side event
    input  wire logic              rx_done_i,
    // line
    output logic                   txd_o,
    output logic                   transceiver_drive_gate_o,
    // interrupt requests and busy flag
    output logic                   tx_irq_o,
    output logic                   rx_irq_o,
    output logic                   timer_irq_o,
    output logic                   busy_o
);

    udg_state_t        state_r;
    logic [BRG_W-1:0]  brg_cnt_r;
    logic              tick;
    logic [3:0]        bit_cnt_r;
    logic [10:0]       shift_r;
    logic              gate_on;
    logic              hold_valid;
    logic              take;
    logic [DATA_W-1:0] hold_data;
    logic [3:0]        last_bit;
    logic              restart;

    udg_hold u_hold (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .wr_i    (tx_wr_i),
        .wdata_i (tx_data_i),
        .take_i  (take),
        .valid_o (hold_valid),
        .rdata_o (hold_data)
    );

    // bit-rate divider, one-cycle tick per bit period
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            brg_cnt_r <= BRG_RESET;
        end else if (restart) begin
            brg_cnt_r <= brg_reload_i;
        end else if (brg_cnt_r <= CNT_ONE) begin
            brg_cnt_r <= brg_reload_i;
        end else begin
            brg_cnt_r <= brg_cnt_r - CNT_ONE;
        end
    end
    assign tick = (brg_cnt_r <= CNT_ONE);

    assign last_bit = ctrl_i.parity_enable ? FRAME_BITS - LEAD_BITS
                                           : FRAME_BITS - LEAD_BITS - LEAD_BITS;
    assign take = ctrl_i.serial_enable && hold_valid &&
                  ((state_r == UDG_IDLE) ||
                   (state_r == UDG_SEND && tick && bit_cnt_r == last_bit) ||
                   (state_r == UDG_TAIL));
    // a frame from rest restarts the divider, so lead and start bit are whole bit periods
    // whatever phase the free-running divider had
    assign restart = take && (state_r == UDG_IDLE || state_r == UDG_TAIL);

    // frame sequencer
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_r   <= UDG_IDLE;
            bit_cnt_r <= BIT_ZERO;
            shift_r   <= '1;
        end else begin
            case (state_r)
                UDG_IDLE: begin
                    if (take) begin
                        state_r   <= UDG_LEAD;
                        bit_cnt_r <= BIT_ZERO;
                        shift_r   <= {1'b1, ^hold_data ^ ctrl_i.parity_odd, hold_data, 1'b0};
                    end
                end
                UDG_LEAD: begin
                    // divider restarted at the take: two ticks give two whole bit periods
                    if (tick) begin
                        if (bit_cnt_r == LEAD_BITS) begin
                            state_r   <= UDG_SEND;
                            bit_cnt_r <= BIT_ZERO;
                        end else begin
                            bit_cnt_r <= bit_cnt_r + LEAD_BITS;
                        end
                    end
                end
                UDG_SEND: begin
                    if (tick) begin
                        if (bit_cnt_r == last_bit) begin
                            if (take) begin
                                bit_cnt_r <= BIT_ZERO;
                                shift_r   <= {1'b1, ^hold_data ^ ctrl_i.parity_odd,
                                              hold_data, 1'b0};
                            end else begin
                                state_r   <= UDG_TAIL;
                            end
                        end else begin
                            bit_cnt_r <= bit_cnt_r + LEAD_BITS;
                            shift_r   <= ctrl_i.parity_enable || bit_cnt_r != 4'(DATA_W)
                                         ? {1'b1, shift_r[10:1]}
                                         : {2'b11, shift_r[10:2]};
                        end
                    end
                end
                UDG_TAIL: begin
                    // one clock after the stop bit
                    if (take) begin
                        state_r   <= UDG_SEND;
                        bit_cnt_r <= BIT_ZERO;
                        shift_r   <= {1'b1, ^hold_data ^ ctrl_i.parity_odd, hold_data, 1'b0};
                    end else begin
                        state_r   <= UDG_IDLE;
                    end
                end
                default: begin
                    state_r <= UDG_IDLE;
                end
            endcase
        end
    end

    assign gate_on = (state_r != UDG_IDLE);
    assign busy_o  = gate_on;

    // line and gate outputs from flops
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            txd_o                    <= 1'b1;
            transceiver_drive_gate_o <= 1'b0;
        end else begin
            txd_o                    <= (state_r == UDG_SEND) ? shift_r[0] : 1'b1;
            transceiver_drive_gate_o <= gate_on ^ ctrl_i.drive_gate_polarity;
        end
    end

    // separate interrupt requests
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            tx_irq_o    <= 1'b0;
            rx_irq_o    <= 1'b0;
            timer_irq_o <= 1'b0;
        end else begin
            tx_irq_o    <= take;
            rx_irq_o    <= rx_done_i && ctrl_i.serial_enable;
            timer_irq_o <= tick && !ctrl_i.serial_enable;
        end
    end

    property p_gate_idle;
        @(posedge clock_i) disable iff (reset_i)
        (state_r == UDG_IDLE) |=>
            (transceiver_drive_gate_o == $past(ctrl_i.drive_gate_polarity));
    endproperty
    a_gate_idle: assert property (p_gate_idle) else $error("gate active while idle");

    property p_gate_frame;
        @(posedge clock_i) disable iff (reset_i)
        (state_r == UDG_SEND) |=>
            (transceiver_drive_gate_o != $past(ctrl_i.drive_gate_polarity));
    endproperty
    a_gate_frame: assert property (p_gate_frame) else $error("gate off during frame");

    property p_start_from_write;
        @(posedge clock_i) disable iff (reset_i)
        (state_r == UDG_IDLE && take) |=> (state_r == UDG_LEAD);
    endproperty
    a_start_from_write: assert property (p_start_from_write) else $error("write not taken");

    property p_tail_one;
        @(posedge clock_i) disable iff (reset_i)
        (state_r == UDG_TAIL) |=> (state_r != UDG_TAIL);
    endproperty
    a_tail_one: assert property (p_tail_one) else $error("tail longer than one clock");

    property p_back_to_back;
        @(posedge clock_i) disable iff (reset_i)
        (state_r == UDG_TAIL && hold_valid && ctrl_i.serial_enable) |=> (state_r == UDG_SEND);
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("gate dropped between");

    property p_lead_tick;
        @(posedge clock_i) disable iff (reset_i)
        (state_r == UDG_LEAD && !tick) |=> (state_r == UDG_LEAD);
    endproperty
    a_lead_tick: assert property (p_lead_tick) else $error("lead left off tick");

    property p_lead_restart;
        @(posedge clock_i) disable iff (reset_i)
        (state_r == UDG_IDLE && take) |=> (brg_cnt_r == $past(brg_reload_i));
    endproperty
    a_lead_restart: assert property (p_lead_restart) else $error("divider not restarted");

    property p_timer;
        @(posedge clock_i) disable iff (reset_i)
        (tick && !ctrl_i.serial_enable) |=> timer_irq_o;
    endproperty
    a_timer: assert property (p_timer) else $error("timer irq missing");

    property p_tx_irq;
        @(posedge clock_i) disable iff (reset_i)
        $rose(tx_irq_o) |-> $past(hold_valid);
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq without data");

endmodule
`default_nettype wire

// ### sim/udg_xcvr.sv
`timescale 1ns/100ps
`default_nettype none
// line transceiver: passes the serial line only while enabled, bias holds the bus high
module udg_xcvr (
    // from the transmitter
    input  wire logic txd_i,
    input  wire logic gate_i,
    input  wire logic polarity_i,
    // shared bus line
    output logic      bus_o
);
    assign bus_o = (gate_i === ~polarity_i) ? txd_i : 1'h1;
endmodule
`default_nettype wire

// ### sim/udg_tx_test.sv
`timescale 1ns/100ps
`default_nettype none
module udg_tx_test;
    import udg_pkg::*;
    localparam int BIT_CLKS = 4;
    logic              clock;
    logic              reset;
    logic              tx_wr;
    logic              rx_done;
    logic              txd;
    logic              gate;
    logic              tx_irq;
    logic              rx_irq;
    logic              timer_irq;
    logic              busy;
    logic              bus;
    logic              on;
    udg_ctrl_t         ctrl;
    logic [DATA_W-1:0] tx_data;
    int                err_total;
    int                compares;
    int                gap;
    int                irq_n;
    int                tmr_n;

    udg_tx i_dut (.clock_i(clock), .reset_i(reset), .ctrl_i(ctrl),
        .brg_reload_i(16'h0004), .tx_wr_i(tx_wr), .tx_data_i(tx_data),
        .rx_done_i(rx_done), .txd_o(txd), .transceiver_drive_gate_o(gate),
        .tx_irq_o(tx_irq), .rx_irq_o(rx_irq), .timer_irq_o(timer_irq), .busy_o(busy));
    udg_xcvr i_xcvr (.txd_i(txd), .gate_i(gate), .polarity_i(ctrl.drive_gate_polarity),
        .bus_o(bus));

    assign on = (gate === ~ctrl.drive_gate_polarity);

    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    // event counters seen at the active edge
    always @(posedge clock) begin
        if (!on) gap++;
        if (tx_irq === 1'h1) irq_n++;
        if (timer_irq === 1'h1) tmr_n++;
    end

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'h1) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        tx_data = d;
        tx_wr = 1'h1;
        @(negedge clock);
        tx_wr = 1'h0;
    endtask

    task automatic wait_gate();
        int n;
        n = 0;
        while (!on && n < 8) begin
            @(negedge clock);
            n++;
        end
        chk(n <= 3, "gate late after write");
    endtask

    // lead: gate just seen active, so the setup time is measured
    task automatic bits(input logic [9:0] exp, input logic lead);
        int n;
        logic [9:0] got;
        n = 0;
        while (bus !== 1'h0 && n < 20) begin
            @(negedge clock);
            n++;
        end
        if (lead) chk(n >= BIT_CLKS && n <= 2 * BIT_CLKS, "start setup");
        repeat (BIT_CLKS / 2) @(negedge clock);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CLKS) @(negedge clock);
            got[i] = bus;
        end
        chk(got === exp, "frame bits on bus");
    endtask

    task automatic tail();
        int n;
        n = 0;
        while (on && n < 10) begin
            @(negedge clock);
            n++;
        end
        chk(n == 3, "gate release time");
    endtask

    task automatic t_single();
        wr(8'hA5);
        wait_gate();
        gap = 0;
        bits({1'h1, ^8'hA5, 8'hA5}, 1'h1);
        chk(gap == 0, "gate dropped in frame");
        tail();
        repeat (20) @(negedge clock);
        chk(!on && txd === 1'h1, "idle after frame");
    endtask

    task automatic t_b2b();
        irq_n = 0;
        wr(8'h3C);
        wait_gate();
        wr(8'hC3);
        gap = 0;
        bits({1'h1, ^8'h3C, 8'h3C}, 1'h1);
        bits({1'h1, ^8'hC3, 8'hC3}, 1'h0);
        chk(gap == 0, "gate gap between frames");
        tail();
        chk(irq_n == 2, "transmit interrupt count");
    endtask

    task automatic t_pol();
        ctrl.drive_gate_polarity = 1'h1;
        repeat (2) @(negedge clock);
        chk(gate === 1'h1, "inverted idle level");
        wr(8'h5A);
        wait_gate();
        chk(gate === 1'h0, "inverted active level");
        bits({1'h1, ^8'h5A, 8'h5A}, 1'h1);
        tail();
        ctrl.drive_gate_polarity = 1'h0;
        repeat (2) @(negedge clock);
    endtask

    // odd parity, then a frame with no parity bit: stop is followed by the biased idle line
    task automatic t_fmt();
        ctrl.parity_odd = 1'h1;
        wr(8'h0F);
        wait_gate();
        bits({1'h1, ~^8'h0F, 8'h0F}, 1'h1);
        tail();
        ctrl.parity_odd    = 1'h0;
        ctrl.parity_enable = 1'h0;
        wr(8'h96);
        wait_gate();
        bits({2'h3, 8'h96}, 1'h1);
        chk(!on, "gate after short frame");
        ctrl.parity_enable = 1'h1;
        repeat (4) @(negedge clock);
    endtask

    task automatic t_irq();
        rx_done = 1'h1;
        @(negedge clock);
        rx_done = 1'h0;
        if (rx_irq !== 1'h1) @(negedge clock);
        chk(rx_irq === 1'h1 && tx_irq === 1'h0, "receive interrupt");
        ctrl.serial_enable = 1'h0;
        @(negedge clock);
        tmr_n = 0;
        wr(8'h81);
        repeat (39) @(negedge clock);
        chk(tmr_n >= 9 && tmr_n <= 11, "timer tick count");
        chk(!on && busy === 1'h0, "no frame while disabled");
        ctrl.serial_enable = 1'h1;
    endtask

    task automatic end_of_test();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        end_of_test();
    end

    initial begin
        reset = 1'h1;
        tx_wr = 1'h0;
        rx_done = 1'h0;
        tx_data = 8'h00;
        ctrl = '{1'h1, 1'h1, 1'h0, 1'h0};
        err_total = 0;
        compares = 0;
        repeat (5) @(negedge clock);
        reset = 1'h0;
        @(negedge clock);
        chk(gate === 1'h0 && txd === 1'h1, "reset levels");
        t_single();
        t_b2b();
        t_pol();
        t_fmt();
        t_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
